//--- gcr_config_regs.sv
`timescale 1ns/1ps
// ==========================================================
// Graphics configuration register bank
module gcr_config_regs import gcr_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire gcr_bus_req_t bus_req,
  output logic [15:0] rdata,
  // Conversion engine
  input wire logic [9:0] image_width_setting,
  input wire logic [8:0] image_height_setting,
  input wire logic pixel_done,
  output logic [1:0] conv_mode,
  output logic cpu_memory_block,
  output logic [18:0] pixels_left,
  // Display timing
  input wire logic double_buffer_select,
  input wire logic internal_update,
  input wire logic external_update,
  output logic [10:0] display_dots_x,
  output logic [9:0] display_dots_y,
  output logic [6:0] display_base,
  output logic [6:0] render_origin
);
  // ==========================================================
  // Decode
  wire hit_mode = bus_req.addr == GCR_IDX_MODE;
  wire hit_width = bus_req.addr == GCR_IDX_WIDTH;
  wire hit_height = bus_req.addr == GCR_IDX_HEIGHT;
  wire hit_fb0 = bus_req.addr == GCR_IDX_FB0;
  wire hit_fb1 = bus_req.addr == GCR_IDX_FB1;
  wire wr_mode = bus_req.wr && hit_mode;
  wire wr_width = bus_req.wr && hit_width;
  wire wr_height = bus_req.wr && hit_height;
  wire wr_fb0 = bus_req.wr && hit_fb0;
  wire wr_fb1 = bus_req.wr && hit_fb1;
  // Rest of the memory control window is held elsewhere; here it reads zero
  wire in_mem_window = (bus_req.addr >= GCR_IDX_MEM_FIRST) &&
                       (bus_req.addr <= GCR_IDX_MEM_LAST);

  // ==========================================================
  // Retained fields: no reset on purpose, they keep values across reset
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [9:0] width_q;
  logic [8:0] height_q;
  logic [6:0] fb0_q;
  logic [6:0] fb1_q;
  logic conv_done;
  logic cnt_load;
  logic [18:0] cnt_value;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // A host write wins over the automatic clear in the same cycle
  assign mode_d = wr_mode ? bus_req.wdata[1:0] :
                  conv_done ? GCR_MODE_NORMAL : mode_q;

  always_ff @(posedge clock) begin
    mode_q <= mode_d;
    if (wr_width) begin
      width_q <= bus_req.wdata[9:0];
    end
    if (wr_height) begin
      height_q <= bus_req.wdata[8:0];
    end
    if (wr_fb0) begin
      fb0_q <= bus_req.wdata[6:0];
    end
    if (wr_fb1) begin
      fb1_q <= bus_req.wdata[6:0];
    end
  end

  // ==========================================================
  // Conversion mode; the prohibited code behaves as normal mode
  assign conv_mode = (mode_q == GCR_MODE_BAD) ? GCR_MODE_NORMAL : mode_q;
  assign cpu_memory_block = (mode_q == GCR_MODE_YUV);
  assign cnt_load = wr_mode && gcr_conv_active(bus_req.wdata[1:0]);
  assign cnt_value = GCR_PIX_W'(image_width_setting * image_height_setting);

  gcr_pixel_counter u_counter (
    .clock(clock),
    .rst_b(rst_b),
    .load(cnt_load),
    .load_value(cnt_value),
    .dec(pixel_done && gcr_conv_active(mode_q)),
    .count(pixels_left),
    .done(conv_done)
  );

  // ==========================================================
  // Display size and frame buffers
  assign display_dots_x = {1'b0, width_q} + 11'h001;
  assign display_dots_y = {1'b0, height_q} + 10'h001;

  gcr_frame_select u_frame (
    .clock(clock),
    .rst_b(rst_b),
    .fb0_base(fb0_q),
    .fb1_base(fb1_q),
    .double_buffer_select(double_buffer_select),
    .internal_update(internal_update),
    .external_update(external_update),
    .display_base(display_base),
    .render_origin(render_origin)
  );

  // ==========================================================
  // Read path: data one cycle after the strobe, reserved bits zero
  assign rdata_d = !bus_req.rd ? GCR_RDATA_RST :
                   hit_mode ? {14'h0000, mode_q} :
                   hit_width ? {6'h00, width_q} :
                   hit_height ? {7'h00, height_q} :
                   hit_fb0 ? {9'h000, fb0_q} :
                   hit_fb1 ? {9'h000, fb1_q} :
                   in_mem_window ? GCR_RDATA_RST : GCR_RDATA_RST;
  assign rdata = rdata_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= GCR_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Checks
  property p_normal_no_block;
    @(posedge clock) disable iff (!rst_b)
    (mode_q == GCR_MODE_NORMAL) |-> !cpu_memory_block && conv_mode == GCR_MODE_NORMAL;
  endproperty
  a_normal_no_block: assert property (p_normal_no_block) else $error("normal mode blocked");

  property p_yuv_block;
    @(posedge clock) disable iff (!rst_b)
    (wr_mode && bus_req.wdata[1:0] == GCR_MODE_YUV) |=> cpu_memory_block;
  endproperty
  a_yuv_block: assert property (p_yuv_block) else $error("YUV mode did not block host");

  property p_delta_mode;
    @(posedge clock) disable iff (!rst_b)
    (wr_mode && bus_req.wdata[1:0] == GCR_MODE_DELTA) |=>
      conv_mode == GCR_MODE_DELTA && !cpu_memory_block && pixels_left == $past(cnt_value);
  endproperty
  a_delta_mode: assert property (p_delta_mode) else $error("delta mode not entered");

  property p_auto_clear;
    @(posedge clock) disable iff (!rst_b)
    (conv_done && !wr_mode) |=> conv_mode == GCR_MODE_NORMAL;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("select not cleared at end");

  property p_bad_is_normal;
    @(posedge clock) disable iff (!rst_b)
    (mode_q == GCR_MODE_BAD) |-> conv_mode == GCR_MODE_NORMAL && !cpu_memory_block;
  endproperty
  a_bad_is_normal: assert property (p_bad_is_normal) else $error("prohibited code active");

  property p_width_dots;
    @(posedge clock) disable iff (!rst_b)
    wr_width |=> display_dots_x == {1'b0, $past(bus_req.wdata[9:0])} + 11'h001;
  endproperty
  a_width_dots: assert property (p_width_dots) else $error("width dots wrong");

  property p_height_dots;
    @(posedge clock) disable iff (!rst_b)
    wr_height |=> display_dots_y == {1'b0, $past(bus_req.wdata[8:0])} + 10'h001;
  endproperty
  a_height_dots: assert property (p_height_dots) else $error("height dots wrong");

  property p_read_fb0;
    @(posedge clock) disable iff (!rst_b)
    (bus_req.rd && hit_fb0) |=> rdata == {9'h000, $past(fb0_q)};
  endproperty
  a_read_fb0: assert property (p_read_fb0) else $error("frame buffer 0 readback wrong");

  property p_origin_path;
    @(posedge clock) disable iff (!rst_b)
    (external_update && !wr_fb0 && !wr_fb1) ##1 1'b1 |->
      render_origin == ($past(double_buffer_select) ? fb0_q : fb1_q);
  endproperty
  a_origin_path: assert property (p_origin_path) else $error("origin from wrong buffer");

  property p_idle_read_zero;
    @(posedge clock) disable iff (!rst_b)
    !bus_req.rd |=> rdata == GCR_RDATA_RST;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside slot");
endmodule

//--- gcr_pkg.sv
`timescale 1ns/1ps
// Contract
// - Select field zero means normal mode, CPU data stored without conversion.
// - Select 01 converts YUV to RGB and blocks host memory access meanwhile.
// - Select 10 converts delta-YUV pixels to RGB before storing them.
// - Pixel counter loads width times height, counts down, clears select at zero.
// - Both conversion-select bits keep their value through reset.
// - Width field 0 to 3FF gives 1 to 1024 dots, field plus one.
// - Height field 0 to 1FF gives 1 to 512 dots, field plus one.
// - Host writes zero to size reserved bits; reads of them undefined.
// - Display width and height fields keep their value through reset.
// - Each frame-buffer register holds address bits 22 to 16 in bits 6 to 0.
// - Double-buffer flag picks displayed buffer; the other is rendering origin.
// - Display register applies at internal update, origin register at external update.
// - Host writes zero to frame-buffer bits 15 to 7; reads undefined.
// - Both frame-buffer address fields keep their value through reset.
// - Eleven 16-bit memory control registers decoded at word index 008 to 012.
package gcr_pkg;
  // ==========================================================
  // Bus and register map
  localparam int GCR_ADDR_W = 10;
  localparam int GCR_DATA_W = 16;
  localparam logic [9:0] GCR_IDX_MODE = 10'h007;
  localparam logic [9:0] GCR_IDX_WIDTH = 10'h008;
  localparam logic [9:0] GCR_IDX_HEIGHT = 10'h009;
  localparam logic [9:0] GCR_IDX_FB0 = 10'h00A;
  localparam logic [9:0] GCR_IDX_FB1 = 10'h00B;
  localparam logic [9:0] GCR_IDX_MEM_FIRST = 10'h008;
  localparam logic [9:0] GCR_IDX_MEM_LAST = 10'h012;
  localparam logic [15:0] GCR_RDATA_RST = 16'h0000;
  // ==========================================================
  // Field widths and reset values
  localparam int GCR_MODE_W = 2;
  localparam int GCR_WIDTH_W = 10;
  localparam int GCR_HEIGHT_W = 9;
  localparam int GCR_BASE_W = 7;
  localparam int GCR_PIX_W = GCR_WIDTH_W + GCR_HEIGHT_W;
  localparam logic [18:0] GCR_CNT_RST = 19'h00000;
  localparam logic [18:0] GCR_CNT_ONE = 19'h00001;
  localparam logic [6:0] GCR_BASE_RST = 7'h00;

  typedef enum logic [1:0] {
    GCR_MODE_NORMAL = 2'b00,
    GCR_MODE_YUV = 2'b01,
    GCR_MODE_DELTA = 2'b10,
    GCR_MODE_BAD = 2'b11
  } gcr_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [15:0] wdata;
  } gcr_bus_req_t;

  function automatic logic gcr_conv_active(input logic [1:0] m);
    return (m == GCR_MODE_YUV) || (m == GCR_MODE_DELTA);
  endfunction
endpackage

// ==========================================================
// Pixel count-down for a conversion run
module gcr_pixel_counter import gcr_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [18:0] load_value,
  input wire logic dec,
  // Status
  output logic [18:0] count,
  output logic done
);
  logic [18:0] count_q;
  logic [18:0] count_d;
  logic armed_q;
  logic armed_d;

  // Done is raised in the same cycle the armed count reads zero, so a zero-sized image still ends
  assign done = armed_q && (count_q == GCR_CNT_RST) && !load;
  assign count_d = load ? load_value :
                   (dec && count_q != GCR_CNT_RST) ? count_q - GCR_CNT_ONE : count_q;
  assign armed_d = load ? 1'b1 : (done ? 1'b0 : armed_q);
  assign count = count_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= GCR_CNT_RST;
      armed_q <= 1'b0;
    end else begin
      count_q <= count_d;
      armed_q <= armed_d;
    end
  end

  property p_count_dec;
    @(posedge clock) disable iff (!rst_b)
    (dec && !load && count_q != GCR_CNT_RST) |=> (count_q == $past(count_q) - GCR_CNT_ONE);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count did not step down");
endmodule

//--- gcr_frame_select.sv
`timescale 1ns/1ps
// ==========================================================
// Displayed base and rendering origin, taken at their updates
module gcr_frame_select import gcr_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register fields
  input wire logic [6:0] fb0_base,
  input wire logic [6:0] fb1_base,
  input wire logic double_buffer_select,
  // Update events
  input wire logic internal_update,
  input wire logic external_update,
  // Selected addresses
  output logic [6:0] display_base,
  output logic [6:0] render_origin
);
  logic [6:0] disp_src;
  logic [6:0] orig_src;
  logic [6:0] display_base_q;
  logic [6:0] render_origin_q;

  assign disp_src = double_buffer_select ? fb1_base : fb0_base;
  assign orig_src = double_buffer_select ? fb0_base : fb1_base;
  assign display_base = display_base_q;
  assign render_origin = render_origin_q;

  // Register writes only show here once the matching update arrives
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      display_base_q <= GCR_BASE_RST;
      render_origin_q <= GCR_BASE_RST;
    end else begin
      if (internal_update) begin
        display_base_q <= disp_src;
      end
      if (external_update) begin
        render_origin_q <= orig_src;
      end
    end
  end

  property p_disp_upd;
    @(posedge clock) disable iff (!rst_b)
    internal_update |=> display_base_q == $past(disp_src);
  endproperty
  a_disp_upd: assert property (p_disp_upd) else $error("display base not taken");

  property p_orig_hold;
    @(posedge clock) disable iff (!rst_b)
    !external_update |=> $stable(render_origin_q);
  endproperty
  a_orig_hold: assert property (p_orig_hold) else $error("origin moved without update");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Register bank bench
module testbench import gcr_pkg::*;;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  gcr_bus_req_t bus_req = '0;
  logic [9:0] img_w = 10'h002;
  logic [8:0] img_h = 9'h003;
  logic pixel_done = 1'b0;
  logic buf_sel = 1'b0;
  logic int_upd = 1'b0;
  logic ext_upd = 1'b0;
  logic [15:0] rdata;
  logic [1:0] conv_mode;
  logic cpu_memory_block;
  logic [18:0] pixels_left;
  logic [10:0] dots_x;
  logic [9:0] dots_y;
  logic [6:0] display_base;
  logic [6:0] render_origin;
  logic [15:0] d;
  int n_mismatch = 0;
  int total_checks = 0;
  int k;

  always #50 clock = ~clock;

  gcr_config_regs dut (
    .clock(clock), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
    .image_width_setting(img_w), .image_height_setting(img_h),
    .pixel_done(pixel_done), .conv_mode(conv_mode), .cpu_memory_block(cpu_memory_block),
    .pixels_left(pixels_left), .double_buffer_select(buf_sel),
    .internal_update(int_upd), .external_update(ext_upd),
    .display_dots_x(dots_x), .display_dots_y(dots_y),
    .display_base(display_base), .render_origin(render_origin)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge clock);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge clock);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic pulse(input logic pd, input logic iu, input logic eu);
    @(posedge clock);
    pixel_done <= pd;
    int_upd <= iu;
    ext_upd <= eu;
    @(posedge clock);
    pixel_done <= 1'b0;
    int_upd <= 1'b0;
    ext_upd <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    wr(GCR_IDX_WIDTH, 16'h03FF);
    check(dots_x, 32'd1024);
    wr(GCR_IDX_HEIGHT, 16'h01FF);
    check(dots_y, 32'd512);
    rd(GCR_IDX_WIDTH, d);
    check(d, 16'h03FF);
    wr(GCR_IDX_WIDTH, 16'h0000);
    check(dots_x, 32'd1);
    wr(GCR_IDX_HEIGHT, 16'h0000);
    check(dots_y, 32'd1);
    wr(GCR_IDX_FB0, 16'h0015);
    wr(GCR_IDX_FB1, 16'h002A);
    rd(GCR_IDX_FB0, d);
    check(d, 16'h0015);
    rd(GCR_IDX_FB1, d);
    check(d, 16'h002A);
    rd(10'h00C, d);
    check(d, 16'h0000);
    @(posedge clock);
    #1;
    check(rdata, 16'h0000);
    // Normal mode must not consume pixels
    wr(GCR_IDX_MODE, 16'h0000);
    pulse(1'b1, 1'b0, 1'b0);
    check(conv_mode, 2'b00);
    check(pixels_left, 19'h00000);
    wr(GCR_IDX_MODE, 16'h0003);
    check(conv_mode, 2'b00);
    rd(GCR_IDX_MODE, d);
    check(d, 16'h0003);
    wr(GCR_IDX_MODE, 16'h0000);
    // ==========================================================
    // Both conversion modes run down the full pixel count
    for (int m = 1; m <= 2; m++) begin
      wr(GCR_IDX_MODE, 16'(m));
      check(conv_mode, 32'(m));
      check(cpu_memory_block, 32'(m == 1));
      check(pixels_left, 32'(img_w * img_h));
      for (int i = 0; i < img_w * img_h; i++) begin
        check(conv_mode, 32'(m));
        pulse(1'b1, 1'b0, 1'b0);
      end
      k = 0;
      while (conv_mode !== 2'b00 && k < 8) begin
        @(posedge clock);
        #1;
        k++;
      end
      // A conversion that never ends is a failure, not a silent pass
      if (k == 8) begin
        n_mismatch++;
        complete_run();
      end
      check(pixels_left, 19'h00000);
      check(cpu_memory_block, 1'b0);
      rd(GCR_IDX_MODE, d);
      check(d, 16'h0000);
    end
    // ==========================================================
    // Frame buffer selection
    pulse(1'b0, 1'b1, 1'b0);
    check(display_base, 7'h15);
    pulse(1'b0, 1'b0, 1'b1);
    check(render_origin, 7'h2A);
    @(posedge clock);
    buf_sel <= 1'b1;
    pulse(1'b0, 1'b1, 1'b1);
    check(display_base, 7'h2A);
    check(render_origin, 7'h15);
    // A written base waits for its update event
    wr(GCR_IDX_FB1, 16'h007F);
    wr(GCR_IDX_FB0, 16'h0033);
    check(display_base, 7'h2A);
    pulse(1'b0, 1'b1, 1'b0);
    check(display_base, 7'h7F);
    check(render_origin, 7'h15);
    pulse(1'b0, 1'b0, 1'b1);
    check(render_origin, 7'h33);
    check(display_base, 7'h7F);
    // ==========================================================
    // Fields survive a reset in mid-run
    wr(GCR_IDX_WIDTH, 16'h0155);
    wr(GCR_IDX_HEIGHT, 16'h00AA);
    wr(GCR_IDX_MODE, 16'h0003);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(GCR_IDX_MODE, d);
    check(d, 16'h0003);
    rd(GCR_IDX_WIDTH, d);
    check(d, 16'h0155);
    check(dots_x, 32'h156);
    rd(GCR_IDX_HEIGHT, d);
    check(d, 16'h00AA);
    rd(GCR_IDX_FB0, d);
    check(d, 16'h0033);
    rd(GCR_IDX_FB1, d);
    check(d, 16'h007F);
    complete_run();
  end
endmodule
